// ===== ahb_pkg.sv
/*
 Package for the host bus port with acknowledge chain: timing counts,
 service classes and bus widths shared by the device end and the host end.
 Assumes a single 10 MHz core clock on both ends.
*/
package ahb_pkg;
   // Core clock period in ns
   localparam int CLK_PERIOD_NS = 100;
   // Acknowledge delay, option clear: 1.5 periods plus 30 ns
   localparam int ACK_DLY0_NS = 180;
   // Acknowledge delay, option set: 2.0 periods plus 35 ns
   localparam int ACK_DLY1_NS = 235;
   // Longest times round down, never below one cycle
   localparam int ACK_DLY0_CYC = (ACK_DLY0_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : (ACK_DLY0_NS / CLK_PERIOD_NS);
   localparam int ACK_DLY1_CYC = (ACK_DLY1_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : (ACK_DLY1_NS / CLK_PERIOD_NS);
   // Request deassert / reassert bound: two periods plus 30 ns
   localparam int REQ_TURN_NS = 230;
   localparam int REQ_TURN_CYC = REQ_TURN_NS / CLK_PERIOD_NS;
   // Address setup before chain acknowledge falls
   localparam int ACK_ADDR_SETUP_NS = 10;
   localparam int ACK_ADDR_SETUP_CYC = (ACK_ADDR_SETUP_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   // Bus widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   // Service classes carried on the acknowledge address low bits
   typedef enum logic [1:0] {SVC_NONE, SVC_RX, SVC_TX, SVC_MODEM} ahb_svc_t;
   localparam logic [1:0] SVC_FIELD_LSB = 2'h0;
endpackage : ahb_pkg

// ===== ahb_if.sv
/*
 Bus between host and device: chip select, data strobe or read/write
 strobes, open-drain transfer acknowledge, three-state data and the
 acknowledge chain. Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface ahb_if;
   import ahb_pkg::*;
   // Host-driven controls, all active low, and the address
   logic cs_n;
   logic data_strobe_n;
   logic rw_n;
   logic rd_n;
   logic wr_n;
   logic chain_ack_in_n;
   logic [ADDR_W-1:0] addr;
   // Data bus halves and enables (enable low means driving)
   logic [DATA_W-1:0] host_data;
   logic host_data_oe_n;
   logic [DATA_W-1:0] dev_data;
   logic dev_data_oe_n;
   // Open-drain acknowledge, pulled high when nobody drives
   logic transfer_ack_oe_n;
   logic transfer_ack_n;
   // Chain and service outputs
   logic chain_ack_out_n;
   logic rx_service_req_n;
   logic tx_service_req_n;
   logic modem_service_req_n;
   // Resolved wire levels
   logic [DATA_W-1:0] data_bus;
   assign transfer_ack_n = transfer_ack_oe_n;
   // Released bus floats to its pull-up level, so a late sample shows it
   assign data_bus = !dev_data_oe_n ? dev_data : !host_data_oe_n ? host_data : {DATA_W{1'b1}};

   modport dev (
      input cs_n, data_strobe_n, rw_n, rd_n, wr_n, chain_ack_in_n, addr, data_bus,
      output dev_data, dev_data_oe_n, transfer_ack_oe_n, chain_ack_out_n,
      output rx_service_req_n, tx_service_req_n, modem_service_req_n
   );
   modport host (
      output cs_n, data_strobe_n, rw_n, rd_n, wr_n, chain_ack_in_n, addr,
      output host_data, host_data_oe_n,
      input data_bus, transfer_ack_n, chain_ack_out_n,
      input rx_service_req_n, tx_service_req_n, modem_service_req_n
   );
endinterface : ahb_if

// ===== ahb_device.sv
/*
 Device end of the host bus port: input synchronisers, strobe gating,
 transfer acknowledge timing, data bus drive, acknowledge chain and
 service request outputs. Assumes host signals are asynchronous to
 core_clk_i and that an end-of-service write is decoded at EOS_ADDR.
*/
// Functional notes
// R01 - Synchronise every host control input to core clock
// R02 - Cycle spans later fall to later rise
// R03 - Acknowledge after strobe, delay set by option
// R04 - Negate acknowledge when strobes return high
// R05 - Drive data only within read strobe
// R06 - Host samples data before removing strobe
// R07 - Acknowledged request drops within two periods
// R08 - End-of-service write re-raises pending requests
// R09 - Host uses chain acknowledge, not chip select
// R10 - Select and direction high before strobe
// R11 - Host holds chain acknowledge until acknowledged
// R12 - Acknowledge address settles before chain falls
// R13 - No match passes chain, stays off bus
// R14 - Chain acknowledge passes downstream promptly
// R15 - Separate read/write strobes alternative handshake
`timescale 1ns/100ps
module ahb_device
   import ahb_pkg::*;
#(
   parameter logic [ADDR_W-1:0] EOS_ADDR = 7'h7f,
   parameter logic [ADDR_W-1:0] MATCH_RX = 7'h01,
   parameter logic [ADDR_W-1:0] MATCH_TX = 7'h02,
   parameter logic [ADDR_W-1:0] MATCH_MODEM = 7'h03,
   parameter logic [DATA_W-1:0] VECTOR_BASE = 8'h40
)(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Option and service sources
   input wire logic ack_delay_option_i,
   input wire logic split_strobes_i,
   input wire logic rx_pending_i,
   input wire logic tx_pending_i,
   input wire logic modem_pending_i,
   input wire logic [DATA_W-1:0] read_data_i,
   // Write path to the core
   output logic wr_strobe_o,
   output logic [ADDR_W-1:0] wr_addr_o,
   output logic [DATA_W-1:0] wr_data_o,
   // Host bus
   ahb_if.dev bus
);
   // Counts must fit the two-bit delay counter
   if (ACK_DLY0_CYC < 1 || ACK_DLY1_CYC < ACK_DLY0_CYC || ACK_DLY1_CYC > 3)
   begin : g_bad_counts
      $error("ahb_device: bad acknowledge counts");
   end

   typedef enum {ST_IDLE, ST_WAIT, ST_ACK, ST_PASS} ahb_dev_state_t;

   // Two-stage synchronisers for the six control inputs
   logic [5:0] sync1_reg, sync2_reg, sync1_next;
   logic cs_s, ds_s, rw_s, rd_s, wr_s, ack_s;
   always_comb
   begin
      sync1_next = {bus.cs_n, bus.data_strobe_n, bus.rw_n, bus.rd_n, bus.wr_n,
                    bus.chain_ack_in_n};
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         sync1_reg <= 6'h3f;
         sync2_reg <= 6'h3f;
      end
      else
      begin
         sync1_reg <= sync1_next;                 // see R01
         sync2_reg <= sync1_reg;
      end
   end
   assign {cs_s, ds_s, rw_s, rd_s, wr_s, ack_s} = sync2_reg;

   // Strobe decode for both handshakes
   logic rd_strobe, wr_strobe_l, any_strobe, ack_cyc, rd_cyc, wr_cyc;
   always_comb
   begin
      rd_strobe = split_strobes_i ? !rd_s : (!ds_s && rw_s);   // see R15
      wr_strobe_l = split_strobes_i ? !wr_s : (!ds_s && !rw_s);
      any_strobe = rd_strobe || wr_strobe_l;
      // Acknowledge cycle needs select high; stops a read being misread
      ack_cyc = !ack_s && cs_s && rd_strobe;                   // see R10
      rd_cyc = !cs_s && rd_strobe;                             // see R02
      wr_cyc = !cs_s && wr_strobe_l;
   end

   // Match the acknowledge address against pending services
   logic hit_rx, hit_tx, hit_mo, hit_any;
   always_comb
   begin
      // Address is stable before the chain input falls, so compare freely
      hit_rx = (bus.addr == MATCH_RX) && !bus.rx_service_req_n;   // see R12
      hit_tx = (bus.addr == MATCH_TX) && !bus.tx_service_req_n;
      hit_mo = (bus.addr == MATCH_MODEM) && !bus.modem_service_req_n;
      hit_any = hit_rx || hit_tx || hit_mo;
   end

   // Cycle state machine
   ahb_dev_state_t state_reg, state_next;
   logic [1:0] cnt_reg, cnt_next;
   logic ack_reg, ack_next, oe_reg, oe_next, pass_reg, pass_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic [1:0] svc_reg, svc_next;
   logic wr_pulse_next;
   logic [1:0] dly;
   always_comb
   begin
      dly = ack_delay_option_i ? 2'(ACK_DLY1_CYC) : 2'(ACK_DLY0_CYC);
      state_next = state_reg;
      cnt_next = cnt_reg;
      ack_next = ack_reg;
      oe_next = oe_reg;
      pass_next = pass_reg;
      dout_next = dout_reg;
      svc_next = 2'h0;
      wr_pulse_next = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            if (ack_cyc && !hit_any)
            begin
               pass_next = 1'b1;                  // see R13
               state_next = ST_PASS;
            end
            else if (ack_cyc || rd_cyc || wr_cyc)
            begin
               cnt_next = 2'h0;
               state_next = ST_WAIT;
               if (!wr_cyc)
               begin
                  oe_next = 1'b1;                 // see R05
                  dout_next = ack_cyc ? VECTOR_BASE | DATA_W'(bus.addr) : read_data_i;
               end
               else
                  wr_pulse_next = 1'b1;
            end
         end
         ST_WAIT:
         begin
            cnt_next = cnt_reg + 2'h1;
            if (!any_strobe)
            begin
               oe_next = 1'b0;                    // see R05
               state_next = ST_IDLE;
            end
            else if (cnt_reg + 2'h1 >= dly)
            begin
               ack_next = 1'b1;                   // see R03
               state_next = ST_ACK;
               if (!ack_s)
                  svc_next = hit_rx ? 2'h1 : hit_tx ? 2'h2 : 2'h3;   // see R07
            end
         end
         ST_ACK:
         begin
            if (!any_strobe)
               oe_next = 1'b0;                    // see R05
            // Ends only when the last of select and strobe is high again
            if (!any_strobe && cs_s && ack_s)
            begin
               ack_next = 1'b0;                   // see R04
               oe_next = 1'b0;
               state_next = ST_IDLE;
            end
         end
         ST_PASS:
         begin
            // Chain output follows the chain input back up, not the strobe
            if (ack_s)
            begin
               pass_next = 1'b0;
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 2'h0;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
         pass_reg <= 1'b0;
         dout_reg <= 8'h00;
         svc_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ack_reg <= ack_next;
         oe_reg <= oe_next;
         pass_reg <= pass_next;
         dout_reg <= dout_next;
         svc_reg <= svc_next;
      end
   end

   // Service requests: acknowledged class masked until end-of-service write
   logic [2:0] served_reg, served_next, req_reg, req_next;
   logic eos_wr;
   always_comb
   begin
      eos_wr = wr_pulse_next && (bus.addr == EOS_ADDR);
      served_next = served_reg;
      // Clear first so a fresh acknowledge in the same cycle wins
      if (eos_wr)
         served_next = 3'h0;                      // see R08
      if (svc_reg != 2'h0)
         served_next[svc_reg - 2'h1] = 1'b1;      // see R07
      req_next = {modem_pending_i, tx_pending_i, rx_pending_i} & ~served_next;
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         served_reg <= 3'h0;
         req_reg <= 3'h0;
      end
      else
      begin
         served_reg <= served_next;
         req_reg <= req_next;
      end
   end

   // Write capture towards the core
   logic wr_strobe_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [DATA_W-1:0] wr_data_reg;
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         wr_strobe_reg <= 1'b0;
         wr_addr_reg <= 7'h00;
         wr_data_reg <= 8'h00;
      end
      else
      begin
         wr_strobe_reg <= wr_pulse_next;
         wr_addr_reg <= wr_pulse_next ? bus.addr : wr_addr_reg;
         wr_data_reg <= wr_pulse_next ? bus.data_bus : wr_data_reg;
      end
   end

   // Chain pass-through: follows the input unless this device claimed it
   logic chain_reg;
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
         chain_reg <= 1'b1;
      else
         chain_reg <= !(pass_next || (pass_reg && !ack_s));   // see R14
   end

   // Outputs, all from flip-flops; enables low while driving
   assign wr_strobe_o = wr_strobe_reg;
   assign wr_addr_o = wr_addr_reg;
   assign wr_data_o = wr_data_reg;
   assign bus.dev_data = dout_reg;
   assign bus.dev_data_oe_n = !oe_reg;
   assign bus.transfer_ack_oe_n = !ack_reg;
   assign bus.chain_ack_out_n = chain_reg;
   assign bus.rx_service_req_n = !req_reg[0];
   assign bus.tx_service_req_n = !req_reg[1];
   assign bus.modem_service_req_n = !req_reg[2];
endmodule : ahb_device

// ===== ahb_host.sv
/*
 Host end: runs one read, write or service acknowledge cycle per command
 and waits for transfer acknowledge. Assumes the device end on the same
 interface and the same clock.
*/
`timescale 1ns/100ps
module ahb_host
   import ahb_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Command port
   input wire logic cmd_valid_i,
   input wire logic [1:0] cmd_kind_i,
   input wire logic [ADDR_W-1:0] cmd_addr_i,
   input wire logic [DATA_W-1:0] cmd_data_i,
   input wire logic split_strobes_i,
   output logic cmd_ready_o,
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   // Host bus
   ahb_if.host bus
);
   typedef enum {HS_IDLE, HS_SETUP, HS_STROBE, HS_END} ahb_host_state_t;

   ahb_host_state_t st_reg, st_next;
   logic [1:0] kind_reg, kind_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
   logic cs_reg, cs_next, stb_reg, stb_next, chain_ack_in_n_reg, chain_ack_in_n_next, done_reg, done_next;

   // Kinds: 0 read, 1 write, 2 service acknowledge
   always_comb
   begin
      st_next = st_reg;
      kind_next = kind_reg;
      addr_next = addr_reg;
      wd_next = wd_reg;
      rd_next = rd_reg;
      cs_next = cs_reg;
      stb_next = stb_reg;
      chain_ack_in_n_next = chain_ack_in_n_reg;
      done_next = 1'b0;
      case (st_reg)
         HS_IDLE:
            if (cmd_valid_i)
            begin
               kind_next = cmd_kind_i;
               addr_next = cmd_addr_i;
               wd_next = cmd_data_i;
               // Select only for ordinary cycles; chain input waits a cycle
               if (cmd_kind_i != 2'h2)
                  cs_next = 1'b1;                 // see R09
               st_next = HS_SETUP;
            end
         HS_SETUP:
         begin
            stb_next = 1'b1;                      // see R10
            // Address has stood a full cycle before chain input falls
            if (kind_reg == 2'h2)
               chain_ack_in_n_next = 1'b1;                 // see R09 R12
            st_next = HS_STROBE;
         end
         HS_STROBE:
            // Hold everything until acknowledge; capture data before release
            if (!bus.transfer_ack_n)
            begin
               rd_next = bus.data_bus;            // see R06 R11
               stb_next = 1'b0;
               cs_next = 1'b0;
               chain_ack_in_n_next = 1'b0;
               st_next = HS_END;
            end
         HS_END:
            if (bus.transfer_ack_n)
            begin
               done_next = 1'b1;
               st_next = HS_IDLE;
            end
         default: st_next = HS_IDLE;
      endcase
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         st_reg <= HS_IDLE;
         kind_reg <= 2'h0;
         addr_reg <= 7'h00;
         wd_reg <= 8'h00;
         rd_reg <= 8'h00;
         cs_reg <= 1'b0;
         stb_reg <= 1'b0;
         chain_ack_in_n_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         kind_reg <= kind_next;
         addr_reg <= addr_next;
         wd_reg <= wd_next;
         rd_reg <= rd_next;
         cs_reg <= cs_next;
         stb_reg <= stb_next;
         chain_ack_in_n_reg <= chain_ack_in_n_next;
         done_reg <= done_next;
      end
   end

   // Pin mapping; acknowledge cycles read with select high
   logic is_wr;
   assign is_wr = (kind_reg == 2'h1);
   assign bus.cs_n = !cs_reg;
   assign bus.chain_ack_in_n = !chain_ack_in_n_reg;
   assign bus.addr = addr_reg;
   assign bus.rw_n = !is_wr;
   assign bus.data_strobe_n = split_strobes_i ? 1'b1 : !stb_reg;   // see R15
   assign bus.rd_n = !(split_strobes_i && stb_reg && !is_wr);
   assign bus.wr_n = !(split_strobes_i && stb_reg && is_wr);
   assign bus.host_data = wd_reg;
   assign bus.host_data_oe_n = !(is_wr && (cs_reg || stb_reg));
   assign cmd_ready_o = (st_reg == HS_IDLE);
   assign done_o = done_reg;
   assign rdata_o = rd_reg;
endmodule : ahb_host

// ===== ahb_properties.sv
/*
 Checker for the host bus port: watches the interface signals only.
 Assumes one core clock and the default service match values.
*/
`timescale 1ns/100ps
module ahb_properties
   import ahb_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Host controls
   input wire logic cs_n,
   input wire logic data_strobe_n,
   input wire logic rw_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic chain_ack_in_n,
   input wire logic [ADDR_W-1:0] addr,
   // Device answers
   input wire logic dev_data_oe_n,
   input wire logic transfer_ack_n,
   input wire logic chain_ack_out_n,
   input wire logic rx_service_req_n,
   input wire logic tx_service_req_n,
   input wire logic modem_service_req_n
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // Cycle qualifiers; either strobe style counts
   wire stb = !data_strobe_n || !rd_n || !wr_n;
   wire act = stb && (!cs_n || !chain_ack_in_n);
   wire rd_act = (!data_strobe_n && rw_n) || !rd_n;
   wire rw_cyc = stb && !cs_n;
   wire svc = stb && !chain_ack_in_n && cs_n;
   // Synchroniser lag allows a few quiet cycles
   sequence s_quiet; !act [*5]; endsequence
   sequence s_no_rd; !rd_act [*5]; endsequence
   sequence s_ack; $fell(transfer_ack_n); endsequence
   sequence s_svc_ack(logic [ADDR_W-1:0] a); s_ack ##0 (svc && addr == a); endsequence

   AST_ACK_CAUSE: assert property (s_ack |-> $past(act, 1) && $past(act, 2))
      else $error("ack without a qualified strobe");
   AST_ACK_BOUND: assert property ($rose(rw_cyc) |-> ##[3:10] !transfer_ack_n)
      else $error("ack late after strobe");
   AST_ACK_NEGATE: assert property (s_quiet |-> transfer_ack_n)
      else $error("ack held after strobes high");
   AST_DATA_RELEASE: assert property (s_no_rd |-> dev_data_oe_n)
      else $error("data driven outside read");
   AST_DATA_CAUSE: assert property ($fell(dev_data_oe_n) |-> $past(rd_act, 2))
      else $error("data driven before read strobe");
   AST_RX_DROP: assert property (s_svc_ack(7'h01) |-> ##[0:2] rx_service_req_n)
      else $error("rx request not dropped");
   AST_TX_DROP: assert property (s_svc_ack(7'h02) |-> ##[0:2] tx_service_req_n)
      else $error("tx request not dropped");
   AST_MODEM_DROP: assert property (s_svc_ack(7'h03) |-> ##[0:2] modem_service_req_n)
      else $error("modem request not dropped");
   AST_NOMATCH_QUIET: assert property (!chain_ack_out_n |-> transfer_ack_n && dev_data_oe_n)
      else $error("passed chain but answered");
   AST_CHAIN_RELEASE: assert property (chain_ack_in_n [*4] |-> chain_ack_out_n)
      else $error("chain output stuck low");
   AST_ADDR_SETUP: assert property ($fell(chain_ack_in_n) |-> $stable(addr))
      else $error("address moved with chain input");
endmodule : ahb_properties

// ===== async_host_bus_ack_chain_bench.sv
/*
 Bench joining host end and device end through the bus interface.
 Assumes the checker file and the package are compiled first.
*/
`timescale 1ns/100ps
module async_host_bus_ack_chain_bench;
   import ahb_pkg::*;
   localparam int D = 10;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic opt = 1'b0;
   logic split = 1'b0;
   logic [2:0] pend = 3'h0;
   logic [DATA_W-1:0] rd_src = 8'h00;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_kind = 2'h0;
   logic [ADDR_W-1:0] cmd_addr = 7'h00;
   logic [DATA_W-1:0] cmd_data = 8'h00;
   logic cmd_ready;
   logic done;
   logic wr_stb;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] wr_data;
   logic [ADDR_W-1:0] wr_addr;
   logic wr_seen = 1'b0;
   logic [ADDR_W-1:0] seen_addr = 7'h00;
   logic [DATA_W-1:0] seen_data = 8'h00;
   logic [2:0] reqs;
   int bad_count = 0;
   int total_checks = 0;
   int lat [2];

   // Free-running core clock
   always #50 core_clk_i = ~core_clk_i;
   ahb_if i_ahb_if ();
   assign reqs = {i_ahb_if.modem_service_req_n, i_ahb_if.tx_service_req_n,
                  i_ahb_if.rx_service_req_n};
   ahb_device i_ahb_device (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .ack_delay_option_i(opt), .split_strobes_i(split), .rx_pending_i(pend[0]),
      .tx_pending_i(pend[1]), .modem_pending_i(pend[2]), .read_data_i(rd_src),
      .wr_strobe_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .bus(i_ahb_if));
   ahb_host i_ahb_host (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
      .cmd_kind_i(cmd_kind), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
      .split_strobes_i(split), .cmd_ready_o(cmd_ready), .done_o(done), .rdata_o(rdata),
      .bus(i_ahb_if));
   ahb_properties i_ahb_properties (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .cs_n(i_ahb_if.cs_n), .data_strobe_n(i_ahb_if.data_strobe_n), .rw_n(i_ahb_if.rw_n),
      .rd_n(i_ahb_if.rd_n), .wr_n(i_ahb_if.wr_n), .chain_ack_in_n(i_ahb_if.chain_ack_in_n),
      .addr(i_ahb_if.addr), .dev_data_oe_n(i_ahb_if.dev_data_oe_n),
      .transfer_ack_n(i_ahb_if.transfer_ack_n), .chain_ack_out_n(i_ahb_if.chain_ack_out_n),
      .rx_service_req_n(i_ahb_if.rx_service_req_n),
      .tx_service_req_n(i_ahb_if.tx_service_req_n),
      .modem_service_req_n(i_ahb_if.modem_service_req_n));

   // Keep the last write handed to the core; the strobe is one cycle
   always @(posedge core_clk_i)
      if (wr_stb)
      begin
         wr_seen <= 1'b1;
         seen_addr <= wr_addr;
         seen_data <= wr_data;
      end

   task complete_run();
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Inputs change a fixed delay after the rising edge
   task tick();
      @(posedge core_clk_i);
      #D;
   endtask : tick

   // One host command; n counts cycles until transfer acknowledge
   task run(input logic [1:0] k, input logic [6:0] a, input logic [7:0] d, output int n);
      bit got;
      got = 0;
      n = 0;
      chk("cmd_ready", 8'h01, cmd_ready);
      cmd_kind = k;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      tick();
      cmd_valid = 1'b0;
      for (int i = 0; i < 80 && done !== 1'b1; i++)
      begin
         if (i_ahb_if.transfer_ack_n === 1'b0)
            got = 1;
         if (!got)
            n++;
         tick();
      end
      if (done !== 1'b1)
      begin
         bad_count++;
         $display("BAD done expected 1 seen %b", done);
         complete_run();
      end
   endtask : run

   // Reads in both strobe styles and both acknowledge delays
   task t_read();
      int n;
      for (int m = 0; m < 4; m++)
      begin
         opt = m[0];
         split = m[1];
         rd_src = 8'h5a ^ m[7:0];
         tick();
         run(2'h0, 7'h10, 8'h00, n);
         chk("rdata", 8'h5a ^ m[7:0], rdata);
         if (!split)
            lat[opt] = n;
         tick();
         chk("dev_data_oe_n", 8'h01, i_ahb_if.dev_data_oe_n);
      end
      chk("ack_delay_step", 8'h01, 8'(lat[1] - lat[0]));
      opt = 1'b0;
   endtask : t_read

   // Writes in both strobe styles
   task t_write();
      int n;
      for (int m = 0; m < 2; m++)
      begin
         split = m[0];
         wr_seen = 1'b0;
         run(2'h1, 7'h22 + m[6:0], 8'ha0 + m[7:0], n);
         chk("wr_seen", 8'h01, wr_seen);
         chk("wr_addr", 8'h22 + m[7:0], seen_addr);
         chk("wr_data", 8'ha0 + m[7:0], seen_data);
      end
      split = 1'b0;
   endtask : t_write

   // Acknowledge each class, then end of service with and without need
   task t_service();
      int n;
      for (int c = 0; c < 3; c++)
      begin
         pend = 3'h1 << c;
         repeat (5) tick();
         chk("req_raised", 8'h00, reqs[c]);
         run(2'h2, 7'(c + 1), 8'h00, n);
         chk("vector", 8'h40 | 8'(c + 1), rdata);
         repeat (5) tick();
         chk("req_masked", 8'h01, reqs[c]);
         run(2'h1, 7'h7f, 8'h00, n);
         repeat (3) tick();
         chk("req_again", 8'h00, reqs[c]);
         run(2'h2, 7'(c + 1), 8'h00, n);
         pend = 3'h0;
         run(2'h1, 7'h7f, 8'h00, n);
         repeat (3) tick();
         chk("req_idle", 8'h01, reqs[c]);
      end
   endtask : t_service

   // Unmatched acknowledge passes the chain; a reset recovers the host
   task t_nomatch();
      pend = 3'h1;
      cmd_kind = 2'h2;
      cmd_addr = 7'h05;
      cmd_valid = 1'b1;
      tick();
      cmd_valid = 1'b0;
      repeat (12) tick();
      chk("chain_out", 8'h00, i_ahb_if.chain_ack_out_n);
      chk("ack_off", 8'h01, i_ahb_if.transfer_ack_n);
      chk("data_off", 8'h01, i_ahb_if.dev_data_oe_n);
      rstn_i = 1'b0;
      pend = 3'h0;
      repeat (3) tick();
      rstn_i = 1'b1;
      repeat (4) tick();
      chk("chain_idle", 8'h01, i_ahb_if.chain_ack_out_n);
      chk("ready_idle", 8'h01, cmd_ready);
   endtask : t_nomatch

   // Main sequence: reset held for twenty cycles
   initial
   begin
      repeat (20) @(posedge core_clk_i);
      #D;
      rstn_i = 1'b1;
      tick();
      chk("ack_reset", 8'h01, i_ahb_if.transfer_ack_n);
      t_read();
      t_write();
      t_service();
      t_nomatch();
      complete_run();
   end
endmodule : async_host_bus_ack_chain_bench
